// File: rtl/sps_edge_detect.sv
`timescale 1ns/1ps
module sps_edge_detect
  import sps_pkg::*;
(
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  // level in, rise strobe out
  input  wire logic i_level,
  input  wire logic i_hold,
  output logic      o_rise
);

  logic level_r;

  // ----------------------------------------
  // previous level, held low while in hold
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level_r <= 1'b0;
    end else begin
      level_r <= i_hold ? 1'b0 : i_level;
    end
  end

  assign o_rise = i_level & ~level_r & ~i_hold;

endmodule

// File: rtl/sps_pkg.sv
// Summary of operation
// - the excitation pattern moves one step only at a rising edge of the step clock input.
// - excitation-mode low selects two-phase stepping, high selects one-two-phase (half) stepping.
// - spin_direction low steps forward (clockwise), high steps in reverse (counter-clockwise).
// - while reset_n is low the sequence is held in reset and all four coil drives are off.
// - while output enable is low all four coil drives are forced off.
// - with output enable low the sequence keeps stepping, so outputs resume in step when it rises.
// - after reset the sequence starts in the state that drives coil_one_fwd and coil_two_rev.
package sps_pkg;

  // ----------------------------------------
  // sequence position
  // ----------------------------------------
  localparam int          SPS_POS_W     = 3;
  localparam logic [2:0]  SPS_POS_RESET = 3'h0;
  localparam logic [2:0]  SPS_POS_ONE   = 3'h1;
  localparam logic [2:0]  SPS_POS_TWO   = 3'h2;

  // ----------------------------------------
  // coil pattern per position, nibble per entry
  // bits: {one_fwd, one_rev, two_fwd, two_rev}
  // ----------------------------------------
  localparam int          SPS_COIL_W    = 4;
  localparam logic [31:0] SPS_PATTERN   = 32'h15462A89;
  localparam logic [3:0]  SPS_COILS_OFF = 4'h0;

  // ----------------------------------------
  // controller timing, for the bench
  // ----------------------------------------
  localparam int SPS_CLK_PERIOD_PS     = 5000;
  localparam int SPS_RESET_MIN_NS      = 10000;
  localparam int SPS_DIR_HOLD_PS       = 6250000;
  localparam int SPS_MODE_HOLD_NS      = 5000;
  localparam int SPS_RESET_MIN_CYC     = (SPS_RESET_MIN_NS * 1000 + SPS_CLK_PERIOD_PS - 1) / SPS_CLK_PERIOD_PS;
  localparam int SPS_DIR_HOLD_CYC      = (SPS_DIR_HOLD_PS + SPS_CLK_PERIOD_PS - 1) / SPS_CLK_PERIOD_PS;
  localparam int SPS_MODE_HOLD_CYC     = (SPS_MODE_HOLD_NS * 1000 + SPS_CLK_PERIOD_PS - 1) / SPS_CLK_PERIOD_PS;

  // ----------------------------------------
  // operating state
  // ----------------------------------------
  typedef enum logic [1:0] {
    SPS_ST_HELD = 2'b01,
    SPS_ST_RUN  = 2'b10
  } sps_state_t;

endpackage

// File: rtl/sps_sequencer.sv
`timescale 1ns/1ps
module sps_sequencer
  import sps_pkg::*;
(
  // clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst_n,
  // controller pins
  input  wire logic                 i_step_clk,
  input  wire logic                 i_exc_mode,
  input  wire logic                 i_spin_direction,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_out_enable,
  // coil drives
  output logic                      o_coil_one_fwd,
  output logic                      o_coil_one_rev,
  output logic                      o_coil_two_fwd,
  output logic                      o_coil_two_rev,
  // status
  output logic [SPS_POS_W-1:0]      o_position
);

  sps_state_t            state_r;
  sps_state_t            state_nxt;
  logic [SPS_POS_W-1:0]  pos_r;
  logic [SPS_POS_W-1:0]  pos_nxt;
  logic [SPS_COIL_W-1:0] coils_r;
  logic [SPS_COIL_W-1:0] coils_nxt;
  logic                  step_rise;
  logic                  held;
  logic [SPS_POS_W-1:0]  stride;
  logic [SPS_POS_W-1:0]  pos_stepped;
  logic [SPS_COIL_W-1:0] pattern;

  // ----------------------------------------
  // step edge detection
  // ----------------------------------------
  assign held = ~i_reset_n;

  sps_edge_detect u_step_edge (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_level   (i_step_clk),
    .i_hold    (held),
    .o_rise    (step_rise)
  );

  // ----------------------------------------
  // next position
  // ----------------------------------------
  // two-phase from a one-coil state moves one place to reach a two-coil state
  assign stride      = (i_exc_mode || pos_r[0]) ? SPS_POS_ONE : SPS_POS_TWO;
  assign pos_stepped = i_spin_direction ? (pos_r - stride) : (pos_r + stride);

  always_comb begin
    state_nxt = state_r;
    pos_nxt   = pos_r;
    case (state_r)
      SPS_ST_HELD: begin
        pos_nxt = SPS_POS_RESET;
        if (!held) begin
          state_nxt = SPS_ST_RUN;
        end
      end
      SPS_ST_RUN: begin
        if (held) begin
          state_nxt = SPS_ST_HELD;
          pos_nxt   = SPS_POS_RESET;
        end else if (step_rise) begin
          pos_nxt = pos_stepped;
        end
      end
      default: begin
        state_nxt = SPS_ST_HELD;
        pos_nxt   = SPS_POS_RESET;
      end
    endcase
  end

  // ----------------------------------------
  // coil decode and gating
  // ----------------------------------------
  assign pattern   = SPS_PATTERN[pos_nxt*SPS_COIL_W +: SPS_COIL_W];
  assign coils_nxt = (held || !i_out_enable) ? SPS_COILS_OFF : pattern;

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= SPS_ST_HELD;
      pos_r   <= SPS_POS_RESET;
      coils_r <= SPS_COILS_OFF;
    end else begin
      state_r <= state_nxt;
      pos_r   <= pos_nxt;
      coils_r <= coils_nxt;
    end
  end

  assign o_coil_one_fwd = coils_r[3];
  assign o_coil_one_rev = coils_r[2];
  assign o_coil_two_fwd = coils_r[1];
  assign o_coil_two_rev = coils_r[0];
  assign o_position     = pos_r;

endmodule

// File: sim/sps_ctrl_model.sv
`timescale 1ns/1ps
module sps_ctrl_model (
  input  wire logic i_clk_sys,
  input  wire logic i_go,
  output logic      o_step_clk = 1'b0
);
  // step clock toggles every cycle while go is held, low at rest
  always @(negedge i_clk_sys) o_step_clk <= i_go && !o_step_clk;
endmodule

// File: sim/sps_sequencer_properties.sv
`timescale 1ns/1ps
module sps_sequencer_properties
  import sps_pkg::*;
(
  input wire logic i_clk_sys, i_rst_n, i_step_clk, i_exc_mode, i_spin_direction, i_reset_n, i_out_enable,
  input wire logic o_coil_one_fwd, o_coil_one_rev, o_coil_two_fwd, o_coil_two_rev,
  input wire logic [SPS_POS_W-1:0] o_position
);
  logic [1:0] prv_r;
  wire stp = i_step_clk && !prv_r[1] && i_reset_n && prv_r[0];
  wire fwd = stp && !i_spin_direction;
  wire [3:0] coils = {o_coil_one_fwd, o_coil_one_rev, o_coil_two_fwd, o_coil_two_rev};
  always_ff @(posedge i_clk_sys) prv_r <= {i_step_clk, i_reset_n};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  chk_idle_hold: assert property (!stp && i_reset_n |=> $stable(o_position)) else $error("moved");
  chk_half_fwd: assert property (fwd && i_exc_mode |=> o_position == $past(o_position) + 3'h1) else $error("half");
  chk_half_rev: assert property (stp && i_spin_direction && i_exc_mode |=> o_position == $past(o_position) - 3'h1)
    else $error("reverse");
  chk_full_fwd: assert property (fwd && !i_exc_mode |=> o_position == (($past(o_position) + 3'h2) & 3'h6))
    else $error("full");
  chk_full_rev: assert property (stp && i_spin_direction && !i_exc_mode |=> o_position == (($past(o_position) - 3'h1) & 3'h6))
    else $error("full reverse");
  chk_reset_off: assert property (!i_reset_n |=> o_position == 3'h0 && coils == 4'h0) else $error("reset");
  chk_enable_off: assert property (!i_out_enable |=> coils == 4'h0) else $error("enable");
  chk_coil_map: assert property (i_out_enable && i_reset_n |=> coils == SPS_PATTERN[{o_position, 2'b00} +: 4])
    else $error("coils");
  chk_gated_step: assert property (stp && !i_out_enable |=> o_position != $past(o_position)) else $error("gated");
  cover property (fwd && i_exc_mode);
  cover property (stp && i_spin_direction && !i_exc_mode);
  cover property (stp && !i_out_enable);
endmodule
bind sps_sequencer sps_sequencer_properties sps_sequencer_properties_i (
  .i_clk_sys        (i_clk_sys),
  .i_rst_n          (i_rst_n),
  .i_step_clk       (i_step_clk),
  .i_exc_mode       (i_exc_mode),
  .i_spin_direction (i_spin_direction),
  .i_reset_n        (i_reset_n),
  .i_out_enable     (i_out_enable),
  .o_coil_one_fwd   (o_coil_one_fwd),
  .o_coil_one_rev   (o_coil_one_rev),
  .o_coil_two_fwd   (o_coil_two_fwd),
  .o_coil_two_rev   (o_coil_two_rev),
  .o_position       (o_position)
);

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
  import sps_pkg::*;
  logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_reset_n = 1'b0, i_exc_mode = 1'b1, i_spin_direction = 1'b0;
  logic i_out_enable = 1'b1, g = 1'b0;
  logic [2:0] e = 3'h0;
  wire i_step_clk, o_coil_one_fwd, o_coil_one_rev, o_coil_two_fwd, o_coil_two_rev;
  wire [SPS_POS_W-1:0] o_position;
  int fail_count = 0, comparisons = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  sps_sequencer sps_sequencer_i (
    .i_clk_sys        (i_clk_sys),
    .i_rst_n          (i_rst_n),
    .i_step_clk       (i_step_clk),
    .i_exc_mode       (i_exc_mode),
    .i_spin_direction (i_spin_direction),
    .i_reset_n        (i_reset_n),
    .i_out_enable     (i_out_enable),
    .o_coil_one_fwd   (o_coil_one_fwd),
    .o_coil_one_rev   (o_coil_one_rev),
    .o_coil_two_fwd   (o_coil_two_fwd),
    .o_coil_two_rev   (o_coil_two_rev),
    .o_position       (o_position)
  );
  sps_ctrl_model sps_ctrl_model_i (.i_clk_sys(i_clk_sys), .i_go(g), .o_step_clk(i_step_clk));
  task automatic end_sim;
    $display("%0d checks, %0d errors", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [6:0] seen, input logic [6:0] want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic look;
    chk({o_position, o_coil_one_fwd, o_coil_one_rev, o_coil_two_fwd, o_coil_two_rev},
        {e, (i_out_enable && i_reset_n) ? SPS_PATTERN[{e, 2'b00} +: 4] : 4'h0});
  endtask
  task automatic step(input int n);
    g <= 1'b1;
    repeat (2 * n) @(negedge i_clk_sys);
    g <= 1'b0;
    if (!i_reset_n) e = 3'h0;
    else if (i_exc_mode) repeat (n) e = e + (i_spin_direction ? 3'h7 : 3'h1);
    else repeat (n) e = (e + (i_spin_direction ? 3'h7 : 3'h2)) & 3'h6;
    @(negedge i_clk_sys);
  endtask
  task automatic set(input logic m, input logic d, input logic en);
    repeat (SPS_DIR_HOLD_CYC) @(negedge i_clk_sys);
    i_exc_mode = m;
    i_spin_direction = d;
    i_out_enable = en;
    repeat (SPS_DIR_HOLD_CYC) @(negedge i_clk_sys);
  endtask
  initial begin
    repeat (30000) @(posedge i_clk_sys);
    fail_count++;
    end_sim;
  end
  initial begin
    repeat (4) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    repeat (SPS_RESET_MIN_CYC) @(negedge i_clk_sys);
    i_reset_n = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    look;
    for (int k = 0; k < 4; k++) begin
      set(!k[0], k[1], 1'b1);
      repeat (9) begin
        step(1);
        look;
      end
    end
    step(3);
    look;
    set(1'b0, 1'b0, 1'b0);
    step(3);
    look;
    set(1'b0, 1'b0, 1'b1);
    look;
    i_reset_n = 1'b0;
    step(2);
    look;
    end_sim;
  end
endmodule
